/* rtl/pmc_clock_ctrl.sv */
`timescale 1ns/10ps
// Contract
// - Internal mode clocks everything internally, primary off
// - Select field 11 enters internal mode
// - Switching to internal stops primary, clears flag
// - Stay internal until primary ready, then switch
// - Primary flag set once primary drives clock
// - Automatic switches leave idle bit and select
// - Low-freq source runs if watchdog or monitor on
// - Sleep on instruction with idle bit clear
// - Sleep stops oscillator, clears all source flags
// - Sleep entry performs no clock switch
// - Sleep keeps low-freq source for watchdog
// - Sleep keeps Timer1 oscillator if enabled
// - Wake holds clock, or internal if two-speed/monitor
// - After wake, flag set when primary supplies
// - Wake leaves idle bit and select unchanged
module pmc_clock_ctrl #(
    parameter int START_CYCLES = pmc_pkg::START_CYCLES
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Register port
    input  wire logic [11:0] regAddr,
    input  wire logic        regWrite,
    input  wire logic [7:0]  regWdata,
    output logic      [7:0]  regRdata,
    // Core events
    input  wire logic        sleepExec,
    input  wire logic        wakeEvent,
    // Configuration
    input  wire logic        watchdogEnable,
    input  wire logic        failSafeEnable,
    input  wire logic        twoSpeedEnable,
    input  wire logic        timer1OscEnable,
    // Oscillator controls
    output logic             primaryOscRun,
    output logic             lowFreqRun,
    output logic             timer1OscRun,
    output logic             internalOscRun,
    // Device clock routing
    output logic      [1:0]  clockSelect,
    output logic             cpuClockEnable,
    output logic             periphClockEnable,
    output logic             sleeping
);
    typedef struct packed {
        logic [1:0]       clock_source_select;
        logic             idleEn;
        pmc_pkg::pmc_src_t src;
        logic             priActive;
        logic             intActive;
        logic             priRun;
    } pmc_state_t;

    pmc_state_t stReg;
    pmc_state_t stNext;
    logic       priReady;
    logic       selWrite;
    logic [7:0] readValue;

    // Primary start-up ready indication
    pmc_startup_timer #(
        .CYCLES (START_CYCLES)
    ) u_tmr (
        .clk_sys (clk_sys),
        .rst     (rst),
        .oscRun  (stReg.priRun),
        .ready   (priReady)
    );

    assign selWrite = regWrite && (regAddr == pmc_pkg::OSC_CTRL_ADDR);

    // Mode sequencing
    always_comb begin
        stNext = stReg;
        // Software only touches idle bit and select
        if (selWrite) begin
            stNext.clock_source_select    = regWdata[pmc_pkg::SCS_MSB:pmc_pkg::SCS_LSB];
            stNext.idleEn = regWdata[pmc_pkg::IDLE_EN_BIT];
        end
        case (stReg.src)
            pmc_pkg::SRC_SLEEP: begin
                if (wakeEvent) begin
                    if (twoSpeedEnable || failSafeEnable) begin
                        stNext.src       = pmc_pkg::SRC_INTERNAL;
                        stNext.intActive = 1'b1;
                    end else begin
                        stNext.src = pmc_pkg::SRC_OFF;
                    end
                    stNext.priRun = (stReg.clock_source_select != pmc_pkg::SCS_INTERNAL);
                end
            end
            pmc_pkg::SRC_OFF: begin
                // No device clock until selected source ready
                if (stReg.clock_source_select == pmc_pkg::SCS_INTERNAL ||
                    stReg.clock_source_select == pmc_pkg::SCS_TIMER1) begin
                    stNext.src = (stReg.clock_source_select == pmc_pkg::SCS_TIMER1) ?
                        pmc_pkg::SRC_TIMER1 : pmc_pkg::SRC_INTERNAL;
                    stNext.intActive = 1'b1;
                    stNext.priRun    = 1'b0;
                end else if (priReady) begin
                    stNext.src       = pmc_pkg::SRC_PRIMARY;
                    stNext.priActive = 1'b1;
                end
            end
            default: begin
                if (sleepExec && !stReg.idleEn) begin
                    stNext.src       = pmc_pkg::SRC_SLEEP;
                    stNext.priRun    = 1'b0;
                    stNext.priActive = 1'b0;
                    stNext.intActive = 1'b0;
                end else if (stReg.clock_source_select == pmc_pkg::SCS_INTERNAL ||
                             stReg.clock_source_select == pmc_pkg::SCS_TIMER1) begin
                    stNext.src = (stReg.clock_source_select == pmc_pkg::SCS_TIMER1) ?
                        pmc_pkg::SRC_TIMER1 : pmc_pkg::SRC_INTERNAL;
                    stNext.priRun    = 1'b0;
                    stNext.priActive = 1'b0;
                    stNext.intActive = 1'b1;
                end else begin
                    // Primary requested: start it, keep current source until ready
                    stNext.priRun = 1'b1;
                    if (stReg.src != pmc_pkg::SRC_PRIMARY && priReady) begin
                        stNext.src       = pmc_pkg::SRC_PRIMARY;
                        stNext.priActive = 1'b1;
                        stNext.intActive = 1'b0;
                    end
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stReg.clock_source_select       <= pmc_pkg::SCS_RESET;
            stReg.idleEn    <= pmc_pkg::IDLE_EN_RESET;
            stReg.src       <= pmc_pkg::SRC_OFF;
            stReg.priActive <= 1'b0;
            stReg.intActive <= 1'b0;
            stReg.priRun    <= 1'b1;
        end else begin
            stReg <= stNext;
        end
    end

    // Register read view
    always_comb begin
        readValue = '0;
        readValue[pmc_pkg::SCS_MSB:pmc_pkg::SCS_LSB] = stReg.clock_source_select;
        readValue[pmc_pkg::IDLE_EN_BIT]    = stReg.idleEn;
        readValue[pmc_pkg::PRI_ACTIVE_BIT] = stReg.priActive;
        readValue[pmc_pkg::INT_ACTIVE_BIT] = stReg.intActive;
        if (regAddr != pmc_pkg::OSC_CTRL_ADDR) begin
            readValue = '0;
        end
    end
    assign regRdata = readValue;

    // Oscillator enables
    assign primaryOscRun  = stReg.priRun;
    assign internalOscRun = (stReg.src == pmc_pkg::SRC_INTERNAL);
    assign lowFreqRun     = watchdogEnable || failSafeEnable
                            || internalOscRun;
    assign timer1OscRun   = timer1OscEnable ||
                            (stReg.src == pmc_pkg::SRC_TIMER1);

    // Clock routing: primary, timer1 or internal
    assign clockSelect = (stReg.src == pmc_pkg::SRC_PRIMARY) ?
                         pmc_pkg::SCS_PRIMARY :
                         (stReg.src == pmc_pkg::SRC_TIMER1) ?
                         pmc_pkg::SCS_TIMER1 : pmc_pkg::SCS_INTERNAL;
    assign cpuClockEnable    = (stReg.src != pmc_pkg::SRC_SLEEP) &&
                               (stReg.src != pmc_pkg::SRC_OFF);
    assign periphClockEnable = cpuClockEnable;
    assign sleeping          = (stReg.src == pmc_pkg::SRC_SLEEP);
endmodule // pmc_clock_ctrl

/* rtl/pmc_pkg.sv */
package pmc_pkg;
    // Register address and field layout of oscillator_control
    localparam logic [11:0] OSC_CTRL_ADDR   = 12'hFD3;
    localparam int          SCS_LSB         = 0;
    localparam int          SCS_MSB         = 1;
    localparam int          PRI_ACTIVE_BIT  = 3;
    localparam int          INT_ACTIVE_BIT  = 2;
    localparam int          IDLE_EN_BIT     = 7;
    localparam logic [7:0]  WRITE_MASK      = 8'h83;

    // Clock source select encodings
    localparam logic [1:0]  SCS_PRIMARY     = 2'h0;
    localparam logic [1:0]  SCS_TIMER1      = 2'h1;
    localparam logic [1:0]  SCS_INTERNAL    = 2'h3;

    // Reset values
    localparam logic [1:0]  SCS_RESET       = 2'h0;
    localparam logic        IDLE_EN_RESET   = 1'b0;

    // Primary start-up timer
    localparam int          START_NS        = 10240;
    localparam int          CLK_NS          = 10;
    localparam int          START_CYCLES    = (START_NS + CLK_NS - 1) / CLK_NS;

    // Which source drives the device clock
    typedef enum logic [2:0] {
        SRC_PRIMARY  = 3'b000,
        SRC_INTERNAL = 3'b001,
        SRC_TIMER1   = 3'b010,
        SRC_OFF      = 3'b011,
        SRC_SLEEP    = 3'b100
    } pmc_src_t;
endpackage

/* rtl/pmc_startup_timer.sv */
`timescale 1ns/10ps
// Counts primary oscillator start-up; ready once expired
module pmc_startup_timer #(
    parameter int CYCLES = pmc_pkg::START_CYCLES,
    parameter int W      = 16
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // Control
    input  wire logic oscRun,
    // Status
    output logic      ready
);
    typedef struct packed {
        logic [W-1:0] count;
        logic         rdy;
    } pmc_tmr_t;

    pmc_tmr_t stReg;
    pmc_tmr_t stNext;

    // Restart whenever the oscillator is stopped
    always_comb begin
        stNext = stReg;
        if (!oscRun) begin
            stNext.count = '0;
            stNext.rdy   = 1'b0;
        end else if (!stReg.rdy) begin
            if (stReg.count == W'(CYCLES - 1)) begin
                stNext.rdy = 1'b1;
            end else begin
                stNext.count = stReg.count + W'(1);
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stReg <= '0;
        end else begin
            stReg <= stNext;
        end
    end

    assign ready = stReg.rdy;
endmodule // pmc_startup_timer

/* sim/pmc_clock_ctrl_props.sv */
`timescale 1ns/10ps
module pmc_clock_ctrl_props #(parameter int START_CYCLES = 8) (
    // Clock, reset and register port
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic [11:0] regAddr,
    input wire logic        regWrite,
    input wire logic [7:0]  regWdata,
    input wire logic [7:0]  regRdata,
    // Events and configuration
    input wire logic        sleepExec,
    input wire logic        wakeEvent,
    input wire logic        watchdogEnable,
    input wire logic        failSafeEnable,
    input wire logic        twoSpeedEnable,
    input wire logic        timer1OscEnable,
    // Oscillator and clock outputs
    input wire logic        primaryOscRun,
    input wire logic        lowFreqRun,
    input wire logic        timer1OscRun,
    input wire logic        internalOscRun,
    input wire logic [1:0]  clockSelect,
    input wire logic        cpuClockEnable,
    input wire logic        periphClockEnable,
    input wire logic        sleeping
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Control register selected on the read port
    wire logic regSel = regAddr == pmc_pkg::OSC_CTRL_ADDR;
    int_mode_a: assert property (
        internalOscRun && regSel && regRdata[1:0] == 2'h3
        |-> !primaryOscRun && cpuClockEnable && periphClockEnable)
        else $error("internal mode with primary running");
    sel_int_a: assert property (
        regWrite && regSel && regWdata[1:0] == 2'h3 && cpuClockEnable
        && !sleepExec |-> ##2 internalOscRun && clockSelect == 2'h3)
        else $error("select 11 did not reach internal mode");
    to_int_a: assert property (
        $rose(internalOscRun) && $past(cpuClockEnable) && regSel
        |-> !primaryOscRun && !regRdata[3])
        else $error("primary not stopped on internal switch");
    keep_int_a: assert property (
        internalOscRun && primaryOscRun
        |-> cpuClockEnable && clockSelect == 2'h3)
        else $error("clock lost while primary starts");
    pri_flag_a: assert property (
        cpuClockEnable && clockSelect == 2'h0 && regSel
        |-> regRdata[3] && !regRdata[2])
        else $error("primary flag wrong while primary runs");
    low_freq_a: assert property (
        watchdogEnable || failSafeEnable |-> lowFreqRun)
        else $error("low frequency source stopped");
    sleep_go_a: assert property (
        sleepExec && cpuClockEnable && !sleeping && regSel && !regRdata[7]
        |=> sleeping && !primaryOscRun && !cpuClockEnable)
        else $error("sleep not entered");
    t1_keep_a: assert property (
        sleeping && timer1OscEnable |-> timer1OscRun)
        else $error("timer1 oscillator stopped in sleep");
    wake_hold_a: assert property (
        sleeping && wakeEvent && !twoSpeedEnable && !failSafeEnable
        |=> !cpuClockEnable ##[1:40] cpuClockEnable)
        else $error("clock not held until ready after wake");
endmodule // pmc_clock_ctrl_props

/* sim/test_pmc_clock_ctrl.sv */
`timescale 1ns/10ps
module test_pmc_clock_ctrl;
    localparam int SC = 8;
    logic        clk_sys, rst, regWrite, sleepExec, wakeEvent;
    logic        watchdogEnable, failSafeEnable, twoSpeedEnable;
    logic        timer1OscEnable, primaryOscRun, lowFreqRun, timer1OscRun;
    logic        internalOscRun, cpuClockEnable, periphClockEnable, sleeping;
    logic [11:0] regAddr;
    logic [7:0]  regWdata, regRdata;
    logic [1:0]  clockSelect;
    int          err_count = 0, total_checks = 0, cycles = 0;

    pmc_clock_ctrl #(.START_CYCLES(SC)) DUT (.*);

    // Compare one value and count it
    task automatic chk(input string nm, input logic [7:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // Register write, one-cycle strobe
    task automatic wr(input logic [7:0] d);
        @(posedge clk_sys);
        regWrite <= 1'b1;
        regWdata <= d;
        @(posedge clk_sys);
        regWrite <= 1'b0;
    endtask
    // One-cycle sleep or wake pulse
    task automatic pulse(input bit wake);
        @(posedge clk_sys);
        if (wake) wakeEvent <= 1'b1;
        else sleepExec <= 1'b1;
        @(posedge clk_sys);
        wakeEvent <= 1'b0;
        sleepExec <= 1'b0;
    endtask
    task automatic t_run_modes();
        wr(8'h03);
        tick(2);
        chk("osc", regRdata, 8'h07);
        chk("pri", 8'(primaryOscRun), 8'h00);
        wr(8'h00);
        tick(2);
        chk("pri", 8'(primaryOscRun), 8'h01);
        chk("sel", 8'(clockSelect), 8'h03);
        tick(SC + 4);
        chk("osc", regRdata, 8'h08);
        @(posedge clk_sys);
        regAddr <= 12'hFD2;
        tick(1);
        chk("unmapped", regRdata, 8'h00);
    endtask
    task automatic t_sleep();
        @(posedge clk_sys);
        regAddr <= pmc_pkg::OSC_CTRL_ADDR;
        watchdogEnable <= 1'b1;
        timer1OscEnable <= 1'b1;
        wr(8'h80);
        pulse(0);
        tick(1);
        chk("idle", 8'(sleeping), 8'h00);
        wr(8'h00);
        pulse(0);
        tick(1);
        chk("slp", 8'(sleeping), 8'h01);
        chk("osc", regRdata, 8'h00);
        chk("pri", 8'(primaryOscRun), 8'h00);
        chk("lf", 8'(lowFreqRun), 8'h01);
        chk("t1", 8'(timer1OscRun), 8'h01);
    endtask
    task automatic t_wake();
        @(posedge clk_sys);
        twoSpeedEnable <= 1'b1;
        pulse(1);
        tick(1);
        chk("int", 8'(internalOscRun), 8'h01);
        tick(SC + 4);
        chk("osc", regRdata, 8'h08);
        @(posedge clk_sys);
        twoSpeedEnable <= 1'b0;
        pulse(0);
        pulse(1);
        tick(1);
        chk("hold", 8'(cpuClockEnable), 8'h00);
        tick(SC + 4);
        chk("osc", regRdata, 8'h08);
    endtask
    // Verdict and end of run
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            err_count++;
            stop_test();
        end
    end
    initial begin
        {rst, regWrite, sleepExec, wakeEvent} = 4'hF;
        {regWrite, sleepExec, wakeEvent} = 3'h0;
        {watchdogEnable, failSafeEnable} = 2'h0;
        {twoSpeedEnable, timer1OscEnable} = 2'h0;
        regAddr = pmc_pkg::OSC_CTRL_ADDR;
        regWdata = 8'h00;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        tick(1);
        chk("boot", 8'(cpuClockEnable), 8'h00);
        tick(SC + 4);
        chk("osc", regRdata, 8'h08);
        t_run_modes();
        t_sleep();
        t_wake();
        stop_test();
    end
endmodule // test_pmc_clock_ctrl

bind pmc_clock_ctrl pmc_clock_ctrl_props #(.START_CYCLES(START_CYCLES))
    u_props (.*);
